// >>> core/fepcs_top.sv
// Fast Ethernet coding path between a MAC nibble port and the line.
`timescale 1ns/1ps
module fepcs_top
   import fepcs_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       resetn,
   input  wire logic       line_clock,
   input  wire logic       tx_en,
   input  wire logic       tx_er,
   input  wire logic [3:0] txd,
   output logic            tx_taken,
   output logic [3:0]      rxd,
   output logic            rx_dv,
   output logic            rx_er,
   output logic            rx_valid,
   output logic            rx_locked,
   output logic            line_tx_pos,
   output logic            line_tx_neg,
   input  wire logic       line_rx_pos,
   input  wire logic       line_rx_neg
);

   // =========================================================
   // Declarations.
   logic        rst_q1;
   logic        line_rstn;
   fepcs_tx_e   tx_state;
   fepcs_tx_e   next_tx_state;
   logic [1:0]  tx_phase;
   logic [1:0]  next_tx_phase;
   logic [2:0]  tx_bitcnt;
   logic [2:0]  next_tx_bitcnt;
   logic [4:0]  tx_sym;
   logic [4:0]  next_tx_sym;
   logic [10:0] tx_lfsr;
   logic [10:0] next_tx_lfsr;
   logic        tx_nrzi;
   logic        next_tx_nrzi;
   logic [1:0]  tx_mlt;
   logic [1:0]  next_tx_mlt;
   logic        tx_req;
   logic        next_tx_req;
   logic        ack_q1;
   logic        ack_q2;
   logic        next_pos;
   logic        next_neg;
   logic        sbit;
   logic        fresh;
   logic        nib_en;
   logic        nib_er;
   logic [3:0]  nib_d;
   logic        req_q1;
   logic        req_q2;
   logic        req_q3;
   logic        tx_ack;
   logic [5:0]  tx_hold;
   logic        rx_prev;
   logic        next_rx_prev;
   logic [10:0] rx_lfsr;
   logic [10:0] next_rx_lfsr;
   logic [4:0]  rx_run;
   logic [4:0]  next_rx_run;
   logic        rx_lock;
   logic        next_rx_lock;
   logic [9:0]  rx_win;
   logic [9:0]  next_rx_win;
   fepcs_rx_e   rx_state;
   fepcs_rx_e   next_rx_state;
   logic [2:0]  rx_bcnt;
   logic [2:0]  next_rx_bcnt;
   logic        rx_tog;
   logic        next_rx_tog;
   logic [5:0]  rx_hold;
   logic [5:0]  next_rx_hold;
   logic        rbit;
   logic        rkey;
   logic        plain;
   logic [4:0]  rsym;
   logic [4:0]  rdec;
   logic        tog_q1;
   logic        tog_q2;
   logic        tog_q3;
   logic        lk_q1;

   fepcs_bit_if bits ();

   // =========================================================
   // Line-domain reset.
   // The system reset is carried into the line domain by two stages.
   always_ff @(posedge line_clock) begin
      rst_q1    <= resetn;
      line_rstn <= rst_q1;
   end

   // =========================================================
   // Transmit coder, line domain.
   // One bit lasts OVS line cycles; a symbol of five bits takes one nibble.
   always_comb begin
      next_tx_state  = tx_state;
      next_tx_phase  = tx_phase + 2'h1;
      next_tx_bitcnt = tx_bitcnt;
      next_tx_sym    = tx_sym;
      next_tx_lfsr   = tx_lfsr;
      next_tx_nrzi   = tx_nrzi;
      next_tx_mlt    = tx_mlt;
      next_tx_req    = tx_req;
      fresh          = (ack_q2 == tx_req);
      nib_en         = fresh & tx_hold[4];
      nib_er         = tx_hold[5];
      nib_d          = tx_hold[3:0];
      sbit           = tx_sym[4] ^ fepcs_key(tx_lfsr);
      if (tx_phase == PH_LAST) begin
         next_tx_lfsr = fepcs_step(tx_lfsr);
         if (sbit) begin
            next_tx_nrzi = ~tx_nrzi;
         end
         if (next_tx_nrzi != tx_nrzi) begin
            next_tx_mlt = tx_mlt + 2'h1;
         end
         if (tx_bitcnt == BIT_LAST) begin
            next_tx_bitcnt = 3'h0;
            if (fresh) begin
               next_tx_req = ~tx_req;
            end
            unique case (tx_state)
               TX_IDLE: begin
                  if (nib_en) begin
                     next_tx_sym   = SYM_J;
                     next_tx_state = TX_K;
                  end else begin
                     next_tx_sym = SYM_I;
                  end
               end
               TX_K: begin
                  next_tx_sym   = SYM_K;
                  next_tx_state = TX_DATA;
               end
               TX_DATA: begin
                  if (nib_en) begin
                     next_tx_sym = nib_er ? SYM_H : CODE5[nib_d];
                  end else begin
                     next_tx_sym   = SYM_T;
                     next_tx_state = TX_R;
                  end
               end
               TX_R: begin
                  next_tx_sym   = SYM_R;
                  next_tx_state = TX_IDLE;
               end
            endcase
         end else begin
            next_tx_bitcnt = tx_bitcnt + 3'h1;
            next_tx_sym    = {tx_sym[3:0], 1'b0};
         end
      end
      next_pos = (next_tx_mlt == 2'h1);
      next_neg = (next_tx_mlt == 2'h3);
   end

   // Registers the transmit coder.
   always_ff @(posedge line_clock) begin
      if (!line_rstn) begin
         tx_state    <= TX_IDLE;
         tx_phase    <= 2'h0;
         tx_bitcnt   <= 3'h0;
         tx_sym      <= SYM_I;
         tx_lfsr     <= LFSR_SEED;
         tx_nrzi     <= 1'b0;
         tx_mlt      <= 2'h0;
         tx_req      <= 1'b0;
         ack_q1      <= 1'b0;
         ack_q2      <= 1'b0;
         line_tx_pos <= 1'b0;
         line_tx_neg <= 1'b0;
      end else begin
         tx_state    <= next_tx_state;
         tx_phase    <= next_tx_phase;
         tx_bitcnt   <= next_tx_bitcnt;
         tx_sym      <= next_tx_sym;
         tx_lfsr     <= next_tx_lfsr;
         tx_nrzi     <= next_tx_nrzi;
         tx_mlt      <= next_tx_mlt;
         tx_req      <= next_tx_req;
         ack_q1      <= tx_ack;
         ack_q2      <= ack_q1;
         line_tx_pos <= next_pos;
         line_tx_neg <= next_neg;
      end
   end

   // =========================================================
   // Receive decoder, line domain.
   fepcs_rx_cdr u_cdr (
      .line_clock (line_clock),
      .line_rstn  (line_rstn),
      .rx_pos     (line_rx_pos),
      .rx_neg     (line_rx_neg),
      .bits       (bits)
   );

   // Unlocked, the generator is loaded from the line assuming idle ones;
   // locked, it runs free and frames are hunted on the J-K pair.
   always_comb begin
      next_rx_prev  = rx_prev;
      next_rx_lfsr  = rx_lfsr;
      next_rx_run   = rx_run;
      next_rx_lock  = rx_lock;
      next_rx_win   = rx_win;
      next_rx_state = rx_state;
      next_rx_bcnt  = rx_bcnt;
      next_rx_tog   = rx_tog;
      next_rx_hold  = rx_hold;
      rbit          = bits.nrzi ^ rx_prev;
      rkey          = fepcs_key(rx_lfsr);
      plain         = rbit ^ rkey;
      rsym          = {rx_win[3:0], plain};
      rdec          = fepcs_dec5(rsym);
      if (bits.strobe) begin
         next_rx_prev = bits.nrzi;
         if (!rx_lock) begin
            next_rx_lfsr = {rx_lfsr[9:0], ~rbit};
            next_rx_run  = (rkey == ~rbit) ? rx_run + 5'h01 : 5'h00;
            if (rx_run == LOCK_RUN) begin
               next_rx_lock = 1'b1;
               next_rx_run  = 5'h00;
            end
         end else begin
            next_rx_lfsr = fepcs_step(rx_lfsr);
            next_rx_win  = {rx_win[8:0], plain};
            unique case (rx_state)
               RX_HUNT: begin
                  next_rx_run = plain ? 5'h00 : rx_run + 5'h01;
                  if ({rx_win[8:0], plain} == {SYM_J, SYM_K}) begin
                     next_rx_state = RX_DATA;
                     next_rx_bcnt  = 3'h0;
                     next_rx_run   = 5'h00;
                  end else if (!plain && rx_run == ZERO_MAX) begin
                     next_rx_lock = 1'b0;
                     next_rx_run  = 5'h00;
                  end
               end
               RX_DATA: begin
                  next_rx_bcnt = rx_bcnt + 3'h1;
                  if (rx_bcnt == BIT_LAST) begin
                     next_rx_bcnt = 3'h0;
                     next_rx_tog  = ~rx_tog;
                     if (rdec[4]) begin
                        next_rx_hold = {2'h2, rdec[3:0]};
                     end else if (rsym == SYM_T) begin
                        next_rx_hold  = 6'h00;
                        next_rx_state = RX_HUNT;
                     end else if (rsym == SYM_I) begin
                        next_rx_hold  = 6'h10;
                        next_rx_state = RX_HUNT;
                     end else begin
                        next_rx_hold = 6'h30;
                     end
                  end
               end
            endcase
         end
      end
   end

   // Registers the receive decoder.
   always_ff @(posedge line_clock) begin
      if (!line_rstn) begin
         rx_prev  <= 1'b0;
         rx_lfsr  <= LFSR_SEED;
         rx_run   <= 5'h00;
         rx_lock  <= 1'b0;
         rx_win   <= 10'h3ff;
         rx_state <= RX_HUNT;
         rx_bcnt  <= 3'h0;
         rx_tog   <= 1'b0;
         rx_hold  <= 6'h00;
      end else begin
         rx_prev  <= next_rx_prev;
         rx_lfsr  <= next_rx_lfsr;
         rx_run   <= next_rx_run;
         rx_lock  <= next_rx_lock;
         rx_win   <= next_rx_win;
         rx_state <= next_rx_state;
         rx_bcnt  <= next_rx_bcnt;
         rx_tog   <= next_rx_tog;
         rx_hold  <= next_rx_hold;
      end
   end

   // =========================================================
   // MAC side, system domain.
   // A toggled request latches the MAC nibble; a toggled hold delivers one.
   always_ff @(posedge clock) begin
      if (!resetn) begin
         req_q1    <= 1'b0;
         req_q2    <= 1'b0;
         req_q3    <= 1'b0;
         tx_ack    <= 1'b0;
         tx_hold   <= 6'h00;
         tx_taken  <= 1'b0;
         tog_q1    <= 1'b0;
         tog_q2    <= 1'b0;
         tog_q3    <= 1'b0;
         rx_valid  <= 1'b0;
         rx_dv     <= 1'b0;
         rx_er     <= 1'b0;
         rxd       <= 4'h0;
         lk_q1     <= 1'b0;
         rx_locked <= 1'b0;
      end else begin
         req_q1    <= tx_req;
         req_q2    <= req_q1;
         req_q3    <= req_q2;
         tx_taken  <= (req_q2 != req_q3);
         if (req_q2 != req_q3) begin
            tx_hold <= {tx_er, tx_en, txd};
            tx_ack  <= req_q2;
         end
         tog_q1    <= rx_tog;
         tog_q2    <= tog_q1;
         tog_q3    <= tog_q2;
         rx_valid  <= (tog_q2 != tog_q3);
         if (tog_q2 != tog_q3) begin
            rx_dv <= rx_hold[5];
            rx_er <= rx_hold[4];
            rxd   <= rx_hold[3:0];
         end
         lk_q1     <= rx_lock;
         rx_locked <= lk_q1;
      end
   end

   // =========================================================
   // Checks.
   // The system reset also masks the first line edges, before the line reset is known.
   a_mlt3_one_level: assert property (
      @(posedge line_clock) disable iff (!line_rstn || !resetn)
      !(line_tx_pos && line_tx_neg))
      else $error("Both MLT3 drivers active.");

   a_mlt3_bit_edge: assert property (
      @(posedge line_clock) disable iff (!line_rstn)
      $changed(tx_mlt) |-> $past(tx_phase) == PH_LAST)
      else $error("MLT3 moved inside a bit.");

   a_nrzi_on_one: assert property (
      @(posedge line_clock) disable iff (!line_rstn)
      (tx_phase == PH_LAST && sbit) |=> $changed(tx_nrzi) && $changed(tx_mlt))
      else $error("A one did not toggle NRZI and step MLT3.");

   a_scr_not_stuck: assert property (
      @(posedge line_clock) disable iff (!line_rstn || !resetn)
      tx_lfsr != 11'h000)
      else $error("Scrambler reached the all-zero state.");

   a_ser_five_bits: assert property (
      @(posedge line_clock) disable iff (!line_rstn)
      (tx_phase == PH_LAST && tx_bitcnt == 3'h0) |-> ##13 tx_bitcnt == BIT_LAST ##4 tx_bitcnt == 3'h0)
      else $error("Symbol not five bits long.");

   a_jk_then_data: assert property (
      @(posedge line_clock) disable iff (!line_rstn)
      (tx_state == TX_K && $changed(tx_state) == 1'b0 && tx_phase == PH_LAST
       && tx_bitcnt == BIT_LAST) |=> tx_state == TX_DATA && tx_sym == SYM_K)
      else $error("K not followed by data.");

   a_req_at_symbol: assert property (
      @(posedge line_clock) disable iff (!line_rstn)
      $changed(tx_req) |-> $past(tx_bitcnt) == BIT_LAST)
      else $error("Nibble requested off a symbol boundary.");

   a_frame_needs_lock: assert property (
      @(posedge line_clock) disable iff (!line_rstn)
      (rx_state == RX_DATA) |-> rx_lock)
      else $error("Frame decoding while unlocked.");

   a_rx_valid_pulse: assert property (
      @(posedge clock) disable iff (!resetn)
      rx_valid |=> !rx_valid [*3])
      else $error("Receive nibbles too close together.");

   c_rx_lock: cover property (
      @(posedge line_clock) disable iff (!line_rstn) $rose(rx_lock));

   c_rx_frame: cover property (
      @(posedge line_clock) disable iff (!line_rstn) $rose(rx_state == RX_DATA));

   c_tx_frame: cover property (
      @(posedge line_clock) disable iff (!line_rstn) tx_state == TX_R);

endmodule : fepcs_top

// >>> core/fepcs_pkg.sv
// Shared constants, code tables and helpers of the fast Ethernet coding path.
// Summary of operation
// - Transmit takes MAC nibbles and sends them as a serial stream at 125 MHz.
// - Transmit nibbles go through 4B/5B coding first and the scrambler after it.
// - The scrambled stream becomes NRZI and is then sent as three-level MLT3.
// - Receive turns the three-level MLT3 input back into a two-level NRZI stream.
// - Receive derives its 125 MHz bit timing from the NRZI transitions.
// - The recovered timing converts NRZI to NRZ for all later receive decoding.
// - The received NRZ stream is descrambled and then 4B/5B decoded into nibbles.
// - Decoded nibbles are delivered to the MAC in parallel MII form.
// - The scrambler is an 11-bit LFSR with a 2047-bit sequence.
// - The descrambler regenerates the far-end sequence and removes it.
package fepcs_pkg;

   // =========================================================
   // Timing.
   localparam int         BIT_HZ   = 125000000;
   localparam int         OVS      = 4;
   localparam int         LINE_HZ  = BIT_HZ * OVS;
   localparam logic [1:0] PH_LAST  = 2'(OVS - 1);
   localparam logic [1:0] PH_MID   = 2'(OVS / 2);
   localparam logic [2:0] BIT_LAST = 3'h4;

   // =========================================================
   // Code groups and lock figures.
   localparam logic [4:0]  SYM_I      = 5'h1f;
   localparam logic [4:0]  SYM_J      = 5'h18;
   localparam logic [4:0]  SYM_K      = 5'h11;
   localparam logic [4:0]  SYM_T      = 5'h0d;
   localparam logic [4:0]  SYM_R      = 5'h07;
   localparam logic [4:0]  SYM_H      = 5'h04;
   localparam logic [10:0] LFSR_SEED  = 11'h7ff;
   localparam logic [4:0]  LOCK_RUN   = 5'h1e;
   localparam logic [4:0]  ZERO_MAX   = 5'h03;
   localparam logic [4:0]  CODE5 [16] = '{5'h1e, 5'h09, 5'h14, 5'h15,
                                          5'h0a, 5'h0b, 5'h0e, 5'h0f,
                                          5'h12, 5'h13, 5'h16, 5'h17,
                                          5'h1a, 5'h1b, 5'h1c, 5'h1d};

   // =========================================================
   // State types.
   typedef enum logic [3:0] {
      TX_IDLE = 4'h1,
      TX_K    = 4'h2,
      TX_DATA = 4'h4,
      TX_R    = 4'h8
   } fepcs_tx_e;

   typedef enum logic [1:0] {
      RX_HUNT = 2'h1,
      RX_DATA = 2'h2
   } fepcs_rx_e;

   // =========================================================
   // Helpers.
   // Key bit of the x^11 + x^9 + 1 sequence.
   function automatic logic fepcs_key(input logic [10:0] s);
      return s[10] ^ s[8];
   endfunction : fepcs_key

   // Advances the sequence generator by one bit.
   function automatic logic [10:0] fepcs_step(input logic [10:0] s);
      return {s[9:0], s[10] ^ s[8]};
   endfunction : fepcs_step

   // Maps a code group to {valid, nibble}.
   function automatic logic [4:0] fepcs_dec5(input logic [4:0] c);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 0; i < 16; i++) begin
         if (CODE5[i] == c) begin
            r = {1'b1, 4'(i)};
         end
      end
      return r;
   endfunction : fepcs_dec5

endpackage : fepcs_pkg

// >>> core/fepcs_bit_if.sv
// Recovered bit stream passed from the clock recovery to the decoder.
`timescale 1ns/1ps
interface fepcs_bit_if;
   logic nrzi;
   logic strobe;
   modport src (output nrzi, output strobe);
   modport snk (input nrzi, input strobe);
endinterface : fepcs_bit_if

// >>> core/fepcs_rx_cdr.sv
// Receive line front: MLT3 to NRZI conversion and bit clock recovery.
`timescale 1ns/1ps
module fepcs_rx_cdr
   import fepcs_pkg::*;
(
   input wire logic  line_clock,
   input wire logic  line_rstn,
   input wire logic  rx_pos,
   input wire logic  rx_neg,
   fepcs_bit_if.src  bits
);

   // =========================================================
   // Pin synchronisers.
   logic [1:0] pin_q1;
   logic [1:0] pin_q2;
   logic [1:0] pin_last;
   logic       nrzi;
   logic       next_nrzi;
   logic [1:0] phase;
   logic [1:0] next_phase;
   logic       strobe;
   logic       next_strobe;

   // Two stages before anything looks at the line levels.
   always_ff @(posedge line_clock) begin
      pin_q1 <= {rx_pos, rx_neg};
      pin_q2 <= pin_q1;
   end

   // =========================================================
   // Conversion and phase tracking.
   // Each MLT3 level change is an NRZI toggle; each toggle re-centres the phase.
   always_comb begin
      next_nrzi  = nrzi;
      next_phase = phase + 2'h1;
      if (pin_q2 != pin_last) begin
         next_nrzi  = ~nrzi;
         next_phase = 2'h0;
      end
      next_strobe = (next_phase == PH_MID);
   end

   // Registers the recovery state.
   always_ff @(posedge line_clock) begin
      if (!line_rstn) begin
         pin_last <= 2'h0;
         nrzi     <= 1'b0;
         phase    <= 2'h0;
         strobe   <= 1'b0;
      end else begin
         pin_last <= pin_q2;
         nrzi     <= next_nrzi;
         phase    <= next_phase;
         strobe   <= next_strobe;
      end
   end

   assign bits.nrzi   = nrzi;
   assign bits.strobe = strobe;

   // =========================================================
   // Checks.
   a_strobe_spacing: assert property (
      @(posedge line_clock) disable iff (!line_rstn)
      strobe |=> !strobe [*2])
      else $error("Bit strobes closer than three cycles.");

   a_nrzi_follows_mlt3: assert property (
      @(posedge line_clock) disable iff (!line_rstn)
      (pin_q2 != pin_last) |=> (nrzi != $past(nrzi)))
      else $error("NRZI did not toggle on an MLT3 change.");

   c_bit_strobe: cover property (
      @(posedge line_clock) disable iff (!line_rstn) strobe);

endmodule : fepcs_rx_cdr

// >>> tb/fepcs_mac_model.sv
// MAC model that feeds transmit nibbles to the coding path on its handshake.
`timescale 1ns/1ps
module fepcs_mac_model (
   input  wire logic       clock,
   input  wire logic       tx_taken,
   output logic            tx_en,
   output logic            tx_er,
   output logic [3:0]      txd
);
   // =========================================================
   // Nibble queue.
   logic [5:0] nibq[$];

   initial begin
      {tx_er, tx_en, txd} = 6'h00;
   end

   // Queues one nibble with its enable and error flags.
   task automatic push(input logic en, input logic er, input logic [3:0] d);
      nibq.push_back({er, en, d});
   endtask : push

   // =========================================================
   // Holds each nibble until it is taken, then shows the next one.
   always @(negedge clock) begin
      if (tx_taken === 1'b1 && nibq.size() > 0) begin
         void'(nibq.pop_front());
      end
      {tx_er, tx_en, txd} <= (nibq.size() > 0) ? nibq[0] : 6'h00;
   end
endmodule : fepcs_mac_model

// >>> tb/tb.sv
// Testbench: the line output is looped back into the receive input.
`timescale 1ns/1ps
module tb;
   import fepcs_pkg::*;
   logic       clock = 1'b0;
   logic       line_clock = 1'b0;
   logic       resetn = 1'b0;
   logic       tx_en, tx_er, tx_taken, rx_dv, rx_er, rx_valid, rx_locked;
   logic [3:0] txd, rxd;
   logic       line_tx_pos, line_tx_neg;
   logic [5:0] rxq[$];
   logic [1:0] lvl_last = 2'h0;
   logic [1:0] nz_last = 2'h0;
   int         err_count = 0;
   int         num_checks = 0;
   int         cyc = 0;

   // =========================================================
   // Clocks, design and MAC model.
   initial begin
      forever #2.5 clock = ~clock;
   end
   initial begin
      #7.3;
      forever #16 line_clock = ~line_clock;
   end

   fepcs_top i_dut (
      .clock(clock), .resetn(resetn), .line_clock(line_clock),
      .tx_en(tx_en), .tx_er(tx_er), .txd(txd), .tx_taken(tx_taken),
      .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er), .rx_valid(rx_valid),
      .rx_locked(rx_locked), .line_tx_pos(line_tx_pos), .line_tx_neg(line_tx_neg),
      .line_rx_pos(line_tx_pos), .line_rx_neg(line_tx_neg)
   );

   fepcs_mac_model i_mac (
      .clock(clock), .tx_taken(tx_taken), .tx_en(tx_en), .tx_er(tx_er), .txd(txd)
   );

   // =========================================================
   // Reporting.
   task automatic chk(input logic [5:0] got, input logic [5:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic conclude();
      $display("checks=%0d errors=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : conclude

   // Collects every received nibble or marker.
   always @(posedge clock) begin
      if (rx_valid === 1'b1) begin
         rxq.push_back({rx_dv, rx_er, rxd});
      end
   end

   // Watches the line: each MLT3 step away from zero has the opposite sign to the last one.
   always @(posedge line_clock) begin
      if ({line_tx_pos, line_tx_neg} !== lvl_last && {line_tx_pos, line_tx_neg} != 2'h0) begin
         chk({4'h0, line_tx_pos, line_tx_neg} == {4'h0, nz_last}, 6'h00);
         nz_last <= {line_tx_pos, line_tx_neg};
      end
      lvl_last <= {line_tx_pos, line_tx_neg};
   end

   // Cuts a hung run short.
   always @(posedge clock) begin
      cyc++;
      if (cyc == 60000) begin
         err_count++;
         conclude();
      end
   end

   // =========================================================
   // Scenarios.
   // Outputs stay quiet during reset.
   task automatic t_reset();
      @(negedge clock);
      chk({tx_taken, rx_valid, rx_locked, rx_dv, line_tx_pos, line_tx_neg},
          6'h00);
   endtask : t_reset

   // Idle from the transmitter brings the descrambler into lock, with no output.
   task automatic t_lock();
      int n;
      n = 0;
      while (rx_locked !== 1'b1 && n < 20000) begin
         @(negedge clock);
         n++;
      end
      chk({5'h00, rx_locked}, 6'h01);
      chk(6'(rxq.size()), 6'h00);
   endtask : t_lock

   // Sends a frame; the first two nibbles become J and K, the rest come back.
   task automatic t_frame(input int len, input int er_at);
      int         n;
      logic [5:0] want;
      rxq.delete();
      for (int i = 0; i < len + 2; i++) begin
         i_mac.push(1'b1, 1'((i - 2) == er_at), 4'(i - 2));
      end
      n = 0;
      while (rxq.size() < len + 1 && n < 8000) begin
         @(negedge clock);
         n++;
      end
      for (int i = 0; i < len; i++) begin
         want = (i == er_at) ? 6'h30 : {2'b10, 4'(i)};
         chk(rxq[i], want);
      end
      chk({4'h0, rxq[len][5:4]}, 6'h00);
   endtask : t_frame

   // =========================================================
   // Main sequence.
   initial begin
      repeat (10) @(negedge clock);
      repeat (4) @(posedge line_clock);
      t_reset();
      @(negedge clock);
      resetn = 1'b1;
      t_lock();
      t_frame(16, -1);
      t_frame(3, 1);
      t_frame(1, -1);
      conclude();
   end
endmodule : tb
